// File: rtl/pep_pkg.sv
/*
 * Constants for the extended page one register bank: register numbers,
 * field positions, reset values and page codes.
 * Assumes register numbers are indexes; byte address is four times index.
 */
package pep_pkg;

  // Register indexes (word number on the bus)
  localparam logic [4:0]  IDX_FIBER_MEDIA_CONTROL   = 5'h10;
  localparam logic [4:0]  IDX_COPPER_GOOD_CRC_COUNT = 5'h12;
  localparam logic [4:0]  IDX_EXTENDED_MODE_CONTROL = 5'h13;
  localparam logic [4:0]  IDX_PAGE_SELECT           = 5'h1f;
  localparam logic [4:0]  IDX_UPPER_FIRST           = 5'h10;
  // Own registers for interrupts, beyond register 31
  localparam logic [5:0]  IDX_IRQ_STATUS            = 6'h20;
  localparam logic [5:0]  IDX_IRQ_MASK              = 6'h21;

  localparam logic [15:0] PAGE_MAIN  = 16'h0000;
  localparam logic [15:0] PAGE_EXT1  = 16'h0001;

  // Fiber media control fields
  localparam int FMC_TX_RF_LSB    = 14;
  localparam int FMC_LP_RF_LSB    = 12;
  localparam int FMC_ALLOW_1000X  = 9;
  localparam int FMC_ALLOW_100FX  = 8;
  localparam int FMC_FAR_FAULT    = 6;
  localparam logic [1:0] FMC_TX_RF_RST = 2'h0;
  localparam logic [1:0] FMC_LP_RF_RST = 2'h0;
  localparam logic       FMC_ALLOW_RST = 1'h1;
  localparam logic       FMC_FAR_FAULT_RST = 1'h0;

  // Good CRC counter fields
  localparam int GCC_SEEN_BIT     = 15;
  localparam logic [13:0] GCC_CNT_RST = 14'h0000;
  localparam logic [13:0] GCC_CNT_MAX = 14'h270f;
  localparam logic        GCC_SEEN_RST = 1'h0;

  // Extended mode control fields
  localparam int EMC_LED_EXT_LSB  = 12;
  localparam int EMC_BLINK_BIT    = 11;
  localparam int EMC_FLF_BIT      = 4;
  localparam int EMC_XOVER_LSB    = 2;
  localparam int EMC_SIGNAL_DETECT_INPUT_BIT   = 0;
  localparam logic [3:0] EMC_LED_EXT_RST = 4'h0;
  localparam logic       EMC_BLINK_RST   = 1'h0;
  localparam logic       EMC_FLF_RST     = 1'h0;
  localparam logic       EMC_SIGNAL_DETECT_INPUT_RST  = 1'h0;
  localparam logic [1:0] XOVER_AUTO  = 2'h0;
  localparam logic [1:0] XOVER_RSVD  = 2'h1;
  localparam logic [1:0] XOVER_MDI   = 2'h2;
  localparam logic [1:0] XOVER_MDIX  = 2'h3;

  // Interrupt status bits
  localparam int IRQ_FAR_FAULT   = 0;
  localparam int IRQ_GOOD_PKT    = 1;
  localparam int IRQ_CNT_WRAP    = 2;
  localparam int IRQ_WIDTH       = 3;

endpackage : pep_pkg

// File: rtl/pep_regs.sv
/*
 * Extended page one register bank of one PHY port, as an APB slave.
 * Assumes datapath status arrives on MCLK; pins pass two flip-flops.
 */
`timescale 1ns/1ps

// Functional notes
// - Writing 0x0001 to page select routes registers 16-30 to page one.
// - Writing 0x0000 to page select returns 16-30 to main space.
// - With page one selected, registers 16-30 reach the page one bank.
// - Registers 0-15 always reach the main space, whatever the page.
// - Two-bit transmit remote fault field, reset 00, sent to partner.
// - Partner remote fault bits captured in a read-only field, reset 00.
// - Sticky allow bit for 1000BASE-X link-up, reset 1.
// - Sticky allow bit for 100BASE-FX link-up, reset 1.
// - Far-end fault flag sets on detection, clears when read.
// - Packet-seen flag sets on copper receive, clears when read.
// - 14-bit good CRC count modulo 10000, wraps after 9999.
// - Good CRC count resets to zero and clears when read.
// - Four extended indicator mode bits, reset 0, drive indicator modes.
// - Blink-after-hold-release bit, reset 0, 1 blinks, 0 suppresses.
// - Fast link failure bit turns general pin nine to failure output.
// - Crossover field: 00 auto, 10 MDI, 11 MDI-X, 01 reserved.
module pep_regs
  import pep_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Main register space for numbers outside page one
  output logic             MAIN_SEL,
  output logic      [4:0]  MAIN_ADDR,
  input  wire logic [15:0] MAIN_RDATA,
  // Datapath status, same clock
  input  wire logic [1:0]  LP_REMOTE_FAULT,
  input  wire logic        LP_REMOTE_FAULT_VALID,
  input  wire logic        FAR_END_FAULT,
  input  wire logic        GOOD_CRC_PACKET,
  input  wire logic        ANY_COPPER_PACKET,
  // Pins, asynchronous
  input  wire logic        LOW_POWER_HOLD_INPUT,
  input  wire logic [3:0]  SIGNAL_DETECT_INPUT,
  // Controls toward the PHY
  output logic      [1:0]  TX_REMOTE_FAULT,
  output logic             ALLOW_1000X_LINK,
  output logic             ALLOW_100FX_LINK,
  output logic      [3:0]  LED_EXTENDED_MODE,
  output logic             LED_BLINK_REQ,
  output logic             GENERAL_PIN_NINE_FLF,
  output logic      [1:0]  XOVER_MODE,
  output logic      [3:0]  SIGNAL_DETECT,
  // Interrupt
  output logic             IRQ
);

  function automatic logic [5:0] word_idx(input logic [7:0] a);
    return a[7:2];
  endfunction

  // Register number match, five-bit number widened to the word index
  function automatic logic idx_is(input logic [5:0] i, input logic [4:0] r);
    return i == {1'b0, r};
  endfunction

  logic [15:0] page_r;
  logic [1:0]  tx_rf_r;
  logic [1:0]  lp_rf_r;
  logic        allow_x_r;
  logic        allow_fx_r;
  logic        far_fault_r;
  logic        seen_r;
  logic [13:0] gcc_r;
  logic [3:0]  led_ext_r;
  logic        blink_r;
  logic        flf_r;
  logic [1:0]  xover_r;
  logic        sigpol_r;
  logic [IRQ_WIDTH-1:0] irq_stat_r;
  logic [IRQ_WIDTH-1:0] irq_mask_r;
  logic        hold_s1_r;
  logic        hold_s2_r;
  logic        hold_d_r;
  logic [3:0]  sig_s1_r;
  logic [3:0]  sig_s2_r;
  logic        blink_pend_r;
  logic [1:0]  xover_out_r;
  logic [3:0]  sig_out_r;

  logic        acc;
  logic        wr;
  logic        rd;
  logic [5:0]  idx;
  logic        ext_hit;
  logic        hit_fmc;
  logic        hit_gcc;
  logic        hit_emc;
  logic        hit_page;
  logic        hit_main;
  logic        hit_stat;
  logic        hit_mask;
  logic        mapped;
  logic        gcc_wrap;
  logic [15:0] rdata;

  assign acc = PSEL && PENABLE;
  assign wr  = acc && PWRITE;
  assign rd  = acc && !PWRITE;
  assign idx = word_idx(PADDR);

  // Upper numbers go to page one only while it is selected
  assign ext_hit  = (page_r == PAGE_EXT1) && (idx < 6'h1f) &&
                    (idx >= {1'b0, IDX_UPPER_FIRST});
  assign hit_fmc  = ext_hit && idx_is(idx, IDX_FIBER_MEDIA_CONTROL);
  assign hit_gcc  = ext_hit && idx_is(idx, IDX_COPPER_GOOD_CRC_COUNT);
  assign hit_emc  = ext_hit && idx_is(idx, IDX_EXTENDED_MODE_CONTROL);
  assign hit_page = idx_is(idx, IDX_PAGE_SELECT);
  assign hit_stat = idx == IDX_IRQ_STATUS;
  assign hit_mask = idx == IDX_IRQ_MASK;
  // Lower numbers always, upper ones when page one is not selected
  assign hit_main = (idx < 6'h1f) && !ext_hit;
  assign mapped   = hit_page || hit_stat || hit_mask || (idx < 6'h1f);

  assign PREADY   = 1'b1;
  assign PSLVERR  = acc && !mapped;
  assign MAIN_SEL  = PSEL && hit_main;
  assign MAIN_ADDR = idx[4:0];

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      page_r <= PAGE_MAIN;
    end else if (wr && hit_page) begin
      page_r <= PWDATA[15:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      tx_rf_r <= FMC_TX_RF_RST;
    end else if (wr && hit_fmc) begin
      tx_rf_r <= PWDATA[FMC_TX_RF_LSB +: 2];
    end
  end

  // Permissions default to allowed so fiber links up unprogrammed
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      allow_x_r  <= FMC_ALLOW_RST;
      allow_fx_r <= FMC_ALLOW_RST;
    end else if (wr && hit_fmc) begin
      allow_x_r  <= PWDATA[FMC_ALLOW_1000X];
      allow_fx_r <= PWDATA[FMC_ALLOW_100FX];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      lp_rf_r <= FMC_LP_RF_RST;
    end else if (LP_REMOTE_FAULT_VALID) begin
      lp_rf_r <= LP_REMOTE_FAULT;
    end
  end

  // Set wins over the read clear so no event is lost
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      far_fault_r <= FMC_FAR_FAULT_RST;
    end else if (FAR_END_FAULT) begin
      far_fault_r <= 1'b1;
    end else if (rd && hit_fmc) begin
      far_fault_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      seen_r <= GCC_SEEN_RST;
    end else if (ANY_COPPER_PACKET) begin
      seen_r <= 1'b1;
    end else if (rd && hit_gcc) begin
      seen_r <= 1'b0;
    end
  end

  assign gcc_wrap = GOOD_CRC_PACKET && (gcc_r == GCC_CNT_MAX);

  // A packet landing on the clearing read counts as one
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      gcc_r <= GCC_CNT_RST;
    end else if (rd && hit_gcc) begin
      gcc_r <= GOOD_CRC_PACKET ? 14'h0001 : GCC_CNT_RST;
    end else if (gcc_wrap) begin
      gcc_r <= GCC_CNT_RST;
    end else if (GOOD_CRC_PACKET) begin
      gcc_r <= gcc_r + 14'h0001;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      led_ext_r <= EMC_LED_EXT_RST;
      blink_r   <= EMC_BLINK_RST;
    end else if (wr && hit_emc) begin
      led_ext_r <= PWDATA[EMC_LED_EXT_LSB +: 4];
      blink_r   <= PWDATA[EMC_BLINK_BIT];
    end
  end

  // Pin and crossover controls; fast failure is meant for port 0 only
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      flf_r    <= EMC_FLF_RST;
      xover_r  <= XOVER_AUTO;
      sigpol_r <= EMC_SIGNAL_DETECT_INPUT_RST;
    end else if (wr && hit_emc) begin
      flf_r    <= PWDATA[EMC_FLF_BIT];
      xover_r  <= PWDATA[EMC_XOVER_LSB +: 2];
      sigpol_r <= PWDATA[EMC_SIGNAL_DETECT_INPUT_BIT];
    end
  end

  // Hold pin synchroniser plus one stage to spot its falling edge
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      hold_s1_r <= 1'b0;
      hold_s2_r <= 1'b0;
      hold_d_r  <= 1'b0;
    end else begin
      hold_s1_r <= LOW_POWER_HOLD_INPUT;
      hold_s2_r <= hold_s1_r;
      hold_d_r  <= hold_s2_r;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sig_s1_r <= 4'h0;
      sig_s2_r <= 4'h0;
    end else begin
      sig_s1_r <= SIGNAL_DETECT_INPUT;
      sig_s2_r <= sig_s1_r;
    end
  end

  // Blink request held until the hold input rises again
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      blink_pend_r <= 1'b0;
    end else if (hold_s2_r) begin
      blink_pend_r <= 1'b0;
    end else if (hold_d_r && blink_r) begin
      blink_pend_r <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      irq_mask_r <= '0;
    end else if (wr && hit_mask) begin
      irq_mask_r <= PWDATA[IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r &
                     ~((wr && hit_stat) ? PWDATA[IRQ_WIDTH-1:0] : '0)) |
                    {gcc_wrap, GOOD_CRC_PACKET, FAR_END_FAULT};
    end
  end

  // Reserved code 01 behaves as automatic crossover
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      xover_out_r <= XOVER_AUTO;
    end else begin
      xover_out_r <= (xover_r == XOVER_RSVD) ? XOVER_AUTO : xover_r;
    end
  end

  // Polarity applied after the synchroniser, never on the raw pin
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sig_out_r <= 4'h0;
    end else begin
      sig_out_r <= sigpol_r ? ~sig_s2_r : sig_s2_r;
    end
  end

  // Kept combinational so a mask write shows on the very next cycle
  assign IRQ = |(irq_stat_r & irq_mask_r);

  // Reserved positions are left zero
  always_comb begin
    rdata = 16'h0000;
    if (hit_page) begin
      rdata = page_r;
    end else if (hit_fmc) begin
      rdata[FMC_TX_RF_LSB +: 2] = tx_rf_r;
      rdata[FMC_LP_RF_LSB +: 2] = lp_rf_r;
      rdata[FMC_ALLOW_1000X]    = allow_x_r;
      rdata[FMC_ALLOW_100FX]    = allow_fx_r;
      rdata[FMC_FAR_FAULT]      = far_fault_r;
    end else if (hit_gcc) begin
      rdata[GCC_SEEN_BIT] = seen_r;
      rdata[13:0]         = gcc_r;
    end else if (hit_emc) begin
      rdata[EMC_LED_EXT_LSB +: 4] = led_ext_r;
      rdata[EMC_BLINK_BIT]        = blink_r;
      rdata[EMC_FLF_BIT]          = flf_r;
      rdata[EMC_XOVER_LSB +: 2]   = xover_r;
      rdata[EMC_SIGNAL_DETECT_INPUT_BIT]       = sigpol_r;
    end else if (ext_hit) begin
      rdata = 16'h0000;
    end else if (hit_main) begin
      rdata = MAIN_RDATA;
    end else if (hit_stat) begin
      rdata[IRQ_WIDTH-1:0] = irq_stat_r;
    end else if (hit_mask) begin
      rdata[IRQ_WIDTH-1:0] = irq_mask_r;
    end
  end

  assign PRDATA = {16'h0000, rdata};

  assign TX_REMOTE_FAULT      = tx_rf_r;
  assign ALLOW_1000X_LINK     = allow_x_r;
  assign ALLOW_100FX_LINK     = allow_fx_r;
  assign LED_EXTENDED_MODE    = led_ext_r;
  assign LED_BLINK_REQ        = blink_pend_r;
  assign GENERAL_PIN_NINE_FLF = flf_r;
  assign XOVER_MODE           = xover_out_r;
  assign SIGNAL_DETECT        = sig_out_r;

endmodule // pep_regs

// File: test/pep_regs_props.sv
/* Checker for the page one bank: page tracking, field updates, reads.
   Assumes zero-wait APB with byte addresses of four times the index. */
`timescale 1ns/1ps
module pep_regs_props
  import pep_pkg::*;
(
  // Clock, reset, bus
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Main space and controls
  input wire logic        MAIN_SEL,
  input wire logic [4:0]  MAIN_ADDR,
  input wire logic [1:0]  TX_REMOTE_FAULT,
  input wire logic        ALLOW_1000X_LINK,
  input wire logic        ALLOW_100FX_LINK,
  input wire logic [3:0]  LED_EXTENDED_MODE,
  input wire logic        GENERAL_PIN_NINE_FLF,
  input wire logic [1:0]  XOVER_MODE
);
  logic        pg_r;
  logic [31:0] wd_r;
  wire         acc = PSEL && PENABLE && PREADY;
  wire         rd1 = acc && !PWRITE && pg_r;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // Own page copy, so page one hits are judged apart from the design
  always_ff @(posedge MCLK) begin
    wd_r <= PWDATA;
    if (RESET)
      pg_r <= 1'b0;
    else if (acc && PWRITE && PADDR == 8'h7c)
      pg_r <= (PWDATA[15:0] == PAGE_EXT1);
  end
  property p_rst;
    $fell(RESET) |-> ALLOW_1000X_LINK && ALLOW_100FX_LINK
      && TX_REMOTE_FAULT == 2'h0 && LED_EXTENDED_MODE == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_fmc;
    acc && PWRITE && pg_r && PADDR == 8'h40 |=> TX_REMOTE_FAULT == wd_r[15:14]
      && ALLOW_1000X_LINK == wd_r[9] && ALLOW_100FX_LINK == wd_r[8];
  endproperty
  a_fmc: assert property (p_fmc) else $error("fiber write lost");
  property p_emc;
    acc && PWRITE && pg_r && PADDR == 8'h4c |=>
      LED_EXTENDED_MODE == wd_r[15:12] && GENERAL_PIN_NINE_FLF == wd_r[4];
  endproperty
  a_emc: assert property (p_emc) else $error("mode write lost");
  property p_xo;
    XOVER_MODE != XOVER_RSVD;
  endproperty
  a_xo: assert property (p_xo) else $error("reserved crossover");
  property p_xw;
    acc && PWRITE && pg_r && PADDR == 8'h4c |-> ##2
      XOVER_MODE == (($past(PWDATA[3:2], 2) == XOVER_RSVD) ? XOVER_AUTO
                     : $past(PWDATA[3:2], 2));
  endproperty
  a_xw: assert property (p_xw) else $error("crossover lost");
  property p_low;
    acc && PADDR < 8'h40 |-> MAIN_SEL && MAIN_ADDR == PADDR[6:2];
  endproperty
  a_low: assert property (p_low) else $error("low index not main");
  property p_page;
    acc && PADDR >= 8'h40 && PADDR <= 8'h78 |-> MAIN_SEL == !pg_r;
  endproperty
  a_page: assert property (p_page) else $error("page routing");
  property p_rsvd;
    rd1 && PADDR == 8'h40 |-> (PRDATA & 32'hffff0cbf) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
  property p_cnt;
    rd1 && PADDR == 8'h48 |-> PRDATA[31:16] == 16'h0 && !PRDATA[14]
      && PRDATA[13:0] <= GCC_CNT_MAX;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count range");
  c_fmc: cover property (acc && PWRITE && pg_r && PADDR == 8'h40);
  c_cnt: cover property (rd1 && PADDR == 8'h48 && PRDATA[15]);
  c_err: cover property (acc && PSLVERR);
endmodule // pep_regs_props
bind pep_regs pep_regs_props chk_u (.MCLK(MCLK), .RESET(RESET),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .MAIN_SEL(MAIN_SEL), .MAIN_ADDR(MAIN_ADDR),
  .TX_REMOTE_FAULT(TX_REMOTE_FAULT), .ALLOW_1000X_LINK(ALLOW_1000X_LINK),
  .ALLOW_100FX_LINK(ALLOW_100FX_LINK), .XOVER_MODE(XOVER_MODE),
  .LED_EXTENDED_MODE(LED_EXTENDED_MODE),
  .GENERAL_PIN_NINE_FLF(GENERAL_PIN_NINE_FLF));

// File: test/tb.sv
/* Self-checking bench for the page one bank, random data, seed 83.
   Assumes zero-wait APB; read data is taken in the access cycle. */
`timescale 1ns/1ps
module tb;
  import pep_pkg::*;
  logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic        lp_v = 0, hold = 0, pready, err, irq, blink, flf, msel;
  logic        a1k, a100, slv;
  logic [2:0]  evs = 3'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic [15:0] mrd = 16'h0;
  logic [1:0]  lp_rf = 2'h0, tx_rf, xo;
  logic [3:0]  sdi = 4'h0, led, sd;
  logic [4:0]  maddr;
  logic [10:0] e;
  int          num_errors = 0, comparisons = 0, cyc = 0, n;
  always #20 mclk = ~mclk;
  pep_regs dut_u (.MCLK(mclk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(slv), .MAIN_SEL(msel),
    .MAIN_ADDR(maddr), .MAIN_RDATA(mrd), .LP_REMOTE_FAULT(lp_rf),
    .LP_REMOTE_FAULT_VALID(lp_v), .FAR_END_FAULT(evs[0]),
    .GOOD_CRC_PACKET(evs[1]), .ANY_COPPER_PACKET(evs[2]),
    .LOW_POWER_HOLD_INPUT(hold), .SIGNAL_DETECT_INPUT(sdi),
    .TX_REMOTE_FAULT(tx_rf), .ALLOW_1000X_LINK(a1k),
    .ALLOW_100FX_LINK(a100), .LED_EXTENDED_MODE(led),
    .LED_BLINK_REQ(blink), .GENERAL_PIN_NINE_FLF(flf),
    .XOVER_MODE(xo), .SIGNAL_DETECT(sd), .IRQ(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Setup, access until ready, then one idle cycle before the next
  task automatic apb(input logic w, input logic [7:0] a, input int wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = slv;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic ev(input int cnt, input logic [2:0] m);
    evs <= m;
    repeat (cnt) @(posedge mclk);
    evs <= 3'h0;
    @(posedge mclk);
  endtask
  function automatic logic [1:0] xo_exp(input logic [1:0] x);
    return (x == XOVER_RSVD) ? XOVER_AUTO : x;
  endfunction
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    void'($urandom(83));
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    apb(1, 8'h7c, 1);
    apb(0, 8'h40, 0);
    chk(rd, 32'h0300);
    apb(0, 8'h48, 0);
    chk(rd, 32'h0);
    apb(0, 8'h4c, 0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = $urandom();
      d[3:2] = i[1:0];
      mrd <= d[31:16];
      sdi <= d[19:16];
      apb(1, 8'h40, d);
      apb(0, 8'h40, 0);
      chk(rd, d & 32'hc300);
      chk({tx_rf, a1k, a100}, {d[15:14], d[9:8]});
      apb(1, 8'h4c, d);
      apb(0, 8'h4c, 0);
      chk(rd, d & 32'hf81d);
      e = {d[15:12], d[4], xo_exp(d[3:2]), d[0] ? ~d[19:16] : d[19:16]};
      chk({led, flf, xo, sd}, e);
      apb(0, 8'h08, 0);
      chk(rd, {16'h0, mrd});
    end
    apb(1, 8'h7c, 0);
    apb(0, 8'h40, 0);
    chk(rd, {16'h0, mrd});
    apb(1, 8'h7c, 1);
    lp_rf <= 2'h2;
    lp_v <= 1'b1;
    @(posedge mclk);
    lp_v <= 1'b0;
    ev(1, 3'h1);
    apb(0, 8'h40, 0);
    chk(rd & 32'h3040, 32'h2040);
    apb(0, 8'h40, 0);
    chk(rd & 32'h3040, 32'h2000);
    chk(irq, 1'b0);
    apb(1, 8'h84, 1);
    chk(irq, 1'b1);
    apb(1, 8'h80, 7);
    chk(irq, 1'b0);
    n = $urandom_range(50, 1);
    ev(n, 3'h6);
    apb(0, 8'h48, 0);
    chk(rd, 32'h8000 | n);
    apb(0, 8'h48, 0);
    chk(rd, 32'h0);
    ev(9999, 3'h6);
    apb(0, 8'h48, 0);
    chk(rd, 32'h8000 | 9999);
    ev(10000, 3'h6);
    apb(0, 8'h48, 0);
    chk(rd, 32'h8000);
    apb(0, 8'h80, 0);
    chk(rd, 32'h6);
    for (int b = 0; b < 2; b++) begin
      apb(1, 8'h4c, b << 11);
      hold <= 1'b1;
      repeat (6) @(posedge mclk);
      hold <= 1'b0;
      repeat (8) @(posedge mclk);
      chk(blink, b[0]);
    end
    apb(0, 8'h88, 0);
    chk(err, 1'b1);
    close_out();
  end
endmodule // tb
